// ---- cmp_analog_model.sv ----
// Behavioural analog front end for the comparator pair
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
  // Commanded levels
  input wire logic [1:0] i_level,
  // Decision per comparator
  output logic [1:0] o_plus_above_minus
);
  assign o_plus_above_minus = i_level;
endmodule
`default_nettype wire

// ---- cmp_mismatch.v ----
// Mismatch detector and change flag for one comparator
`timescale 1ns/1ps
`default_nettype none
module cmp_mismatch (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // Control
  input wire i_phase_first,
  input wire i_read_ctrl,
  input wire i_result,
  input wire i_flag_write,
  input wire i_flag_value,
  // Status
  output reg o_result_seen,
  output reg o_flag
);
  reg read_latch;
  reg phase_latch;
  reg mismatch_prev;
  wire mismatch;
  // Exclusive-or of read copy and phase copy
  assign mismatch = read_latch ^ phase_latch;
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      read_latch <= 1'b0;
      phase_latch <= 1'b0;
      mismatch_prev <= 1'b0;
      o_flag <= 1'b0;
      o_result_seen <= 1'b0;
    end else begin
      if (i_read_ctrl) begin
        read_latch <= i_result;
        o_result_seen <= i_result;
      end
      if (i_phase_first) begin
        phase_latch <= i_result;
      end
      mismatch_prev <= mismatch;
      // Rising edge of mismatch sets the flag and wins over a clear
      if (mismatch && !mismatch_prev) begin
        o_flag <= 1'b1;
      end else if (i_flag_write) begin
        o_flag <= i_flag_value;
      end
    end
  end
endmodule
`default_nettype wire

// ---- cmpctl_assertions.sv ----
// Checker for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmpctl_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Pins and processor
  input wire logic [1:0] i_port_latch,
  input wire logic [1:0] o_comparator_on,
  input wire logic [1:0] o_result_pin,
  input wire logic o_wake,
  input wire logic o_run_next_first,
  input wire logic o_irq_branch
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic drive1;
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wr1 = req && i_wb_we && i_wb_sel[0] && i_wb_adr == 4'h0;
  // Mirror of the first pin drive bit
  always @(posedge i_clk_sys) begin
    if (i_rst)
      drive1 <= 1'b0;
    else if (wr1)
      drive1 <= i_wb_dat[5];
  end
  AST_ACK_NEXT: assert property (req |=> o_wb_ack)
    else $error("no ack");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  AST_RESET: assert property (disable iff (1'b0) i_rst |=> o_comparator_on == 2'h0 && !o_wake)
    else $error("not reset");
  AST_ON_WRITE: assert property (wr1 |=> o_comparator_on[0] == $past(i_wb_dat[7]))
    else $error("on bit");
  AST_READ_ZERO: assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == 4'h0 |-> !o_wb_dat[3])
    else $error("bit 3 set");
  AST_PIN_LATCH: assert property (!drive1 |=> o_result_pin[0] == $past(i_port_latch[0]))
    else $error("pin");
  AST_WAKE_NEXT: assert property (o_wake |-> o_run_next_first)
    else $error("next first");
  AST_WAKE_PULSE: assert property (o_wake |=> !o_wake)
    else $error("wake held");
  AST_WAKE_NO_BRANCH: assert property (o_wake |-> !o_irq_branch)
    else $error("branch with wake");
endmodule
bind cmpctl_top cmpctl_checker chk_i (.*);
`default_nettype wire

// ---- cmpctl_consts.vh ----
// Constants for the comparator control and wake block
`ifndef CMPCTL_CONSTS_VH
`define CMPCTL_CONSTS_VH
// Register byte addresses
`define ADDR_CTRL1 4'h0
`define ADDR_CTRL2 4'h4
`define ADDR_AUX 4'h8
`define ADDR_FLAGS 4'hc
// Control register fields
`define BIT_ON 7
`define BIT_RESULT 6
`define BIT_PIN_DRIVE 5
`define BIT_INVERT 4
`define BIT_REF_SEL 2
`define CTRL_WMASK 8'hb7
`define CTRL_RESET 8'h00
`define AUX_RESET 8'h00
// Flags register fields
`define BIT_FLAG1 0
`define BIT_FLAG2 1
`define BIT_ALLOW1 2
`define BIT_ALLOW2 3
`define BIT_PERIPH 4
`define BIT_GLOBAL 5
`define BIT_ASLEEP 6
`define FLAGS_WMASK 8'h3f
// Instruction clock phases
`define PHASE_FIRST 2'h0
`define PHASE_SECOND 2'h1
`endif

// ---- cmpctl_top.v ----
// Comparator control, change detect and wake block with Wishbone slave
// Behaviour
// - Change during read may miss flag
// - Enabled comparator keeps detecting during sleep
// - Clearing on bit switches comparator off
// - Change wakes when both allows set
// - After wake run next instruction first
// - Global allow then branch to service
// - Reset clears both controls and aux
// - Read latch, phase latch, exclusive-or
// - Flag set on mismatch rising edge
// - Control write also reloads read latch
// - Result high when on bit set, plus exceeds minus and invert bit clear
`timescale 1ns/1ps
`default_nettype none
`include "cmpctl_consts.vh"
module cmpctl_top (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Analog side: raw comparator decisions (plus above minus)
  input wire [1:0] i_plus_above_minus,
  // Port data latches for the result pins
  input wire [1:0] i_port_latch,
  // Processor sleep handshake
  input wire i_sleep_enter,
  // Comparator enables and selects to the analog side
  output wire [1:0] o_comparator_on,
  output wire [1:0] o_reference_select,
  output wire [3:0] o_channel_select,
  output wire [7:0] o_aux_control,
  // Result pins
  output reg [1:0] o_result_pin,
  // Processor wake and interrupt requests
  output reg o_wake,
  output wire o_run_next_first,
  output reg o_irq_branch
);
  reg [7:0] comparator_one_control;
  reg [7:0] comparator_two_control;
  reg [7:0] comparator_aux_control;
  reg [1:0] compare_irq_allow;
  reg peripheral_irq_allow;
  reg global_irq_allow;
  reg asleep;
  reg [1:0] phase;
  reg [1:0] result_now;
  wire [1:0] result_seen;
  wire [1:0] compare_change_flag;
  wire [1:0] read_ctrl;
  wire [1:0] flag_write;
  wire [1:0] flag_value;
  wire access;
  wire wr;
  wire phase_first;
  wire phase_second;
  wire [7:0] flags_view;
  wire pending;
  reg [7:0] read_byte;

  // Pick a control register by index
  function [7:0] ctrl_of;
    input idx;
    input [7:0] one;
    input [7:0] two;
    begin
      ctrl_of = idx ? two : one;
    end
  endfunction

  assign access = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // Only the low byte lane carries register data
  assign wr = access && i_wb_we && i_wb_sel[0];

  // Four-phase instruction clock
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      phase <= `PHASE_FIRST;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign phase_first = (phase == `PHASE_FIRST);
  assign phase_second = (phase == `PHASE_SECOND);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire [7:0] ctrl;
      wire addr_hit;
      assign ctrl = ctrl_of(g == 1, comparator_one_control, comparator_two_control);
      assign addr_hit = access && (i_wb_adr == (g ? `ADDR_CTRL2 : `ADDR_CTRL1));
      // Reads and writes both load the read latch
      assign read_ctrl[g] = addr_hit;
      assign flag_write[g] = wr && (i_wb_adr == `ADDR_FLAGS);
      assign flag_value[g] = i_wb_dat[g ? `BIT_FLAG2 : `BIT_FLAG1];
      assign o_comparator_on[g] = ctrl[`BIT_ON];
      assign o_reference_select[g] = ctrl[`BIT_REF_SEL];
      assign o_channel_select[2*g+1:2*g] = ctrl[1:0];
      // Result sampled every clock, held during a second-phase access, off when disabled
      always @(posedge i_clk_sys) begin
        if (i_rst) begin
          result_now[g] <= 1'b0;
        end else if (phase_second && read_ctrl[g]) begin
          result_now[g] <= result_now[g];
        end else begin
          result_now[g] <= ctrl[`BIT_ON] & (i_plus_above_minus[g] ^ ctrl[`BIT_INVERT]);
        end
      end
      // Pin carries the result when the pin drive bit is set, else the port latch
      always @(posedge i_clk_sys) begin
        if (i_rst) begin
          o_result_pin[g] <= 1'b0;
        end else begin
          o_result_pin[g] <= ctrl[`BIT_PIN_DRIVE] ? result_now[g] : i_port_latch[g];
        end
      end
      cmp_mismatch u_mm (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_phase_first(phase_first),
        .i_read_ctrl(read_ctrl[g]),
        .i_result(result_now[g]),
        .i_flag_write(flag_write[g]),
        .i_flag_value(flag_value[g]),
        .o_result_seen(result_seen[g]),
        .o_flag(compare_change_flag[g])
      );
    end
  endgenerate

  assign o_aux_control = comparator_aux_control;
  assign flags_view = {1'b0, asleep, global_irq_allow, peripheral_irq_allow, compare_irq_allow,
                       compare_change_flag};
  assign pending = |(compare_change_flag & compare_irq_allow) && peripheral_irq_allow;
  assign o_run_next_first = o_wake;

  // Register writes
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      comparator_one_control <= `CTRL_RESET;
      comparator_two_control <= `CTRL_RESET;
      comparator_aux_control <= `AUX_RESET;
      compare_irq_allow <= 2'h0;
      peripheral_irq_allow <= 1'b0;
      global_irq_allow <= 1'b0;
    end else if (wr) begin
      case (i_wb_adr)
        `ADDR_CTRL1: comparator_one_control <= i_wb_dat[7:0] & `CTRL_WMASK;
        `ADDR_CTRL2: comparator_two_control <= i_wb_dat[7:0] & `CTRL_WMASK;
        `ADDR_AUX: comparator_aux_control <= i_wb_dat[7:0];
        `ADDR_FLAGS: begin
          compare_irq_allow <= i_wb_dat[`BIT_ALLOW2:`BIT_ALLOW1];
          peripheral_irq_allow <= i_wb_dat[`BIT_PERIPH];
          global_irq_allow <= i_wb_dat[`BIT_GLOBAL];
        end
        default: ;
      endcase
    end
  end

  // Sleep, wake and interrupt branch
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      asleep <= 1'b0;
      o_wake <= 1'b0;
      o_irq_branch <= 1'b0;
    end else begin
      o_wake <= 1'b0;
      o_irq_branch <= 1'b0;
      if (asleep && pending) begin
        asleep <= 1'b0;
        o_wake <= 1'b1;
      end else if (i_sleep_enter && !pending) begin
        asleep <= 1'b1;
      end
      // After a wake, branch one cycle later, letting the next instruction go first
      if (o_wake && global_irq_allow) begin
        o_irq_branch <= 1'b1;
      end else if (!asleep && !o_wake && pending && global_irq_allow) begin
        o_irq_branch <= 1'b1;
      end
    end
  end

  // Read data mux; in the control registers bit 6 shows the live result, bit 3 reads zero
  always @* begin
    case (i_wb_adr)
      `ADDR_CTRL1: read_byte = {comparator_one_control[7], result_now[0], comparator_one_control[5:0]};
      `ADDR_CTRL2: read_byte = {comparator_two_control[7], result_now[1], comparator_two_control[5:0]};
      `ADDR_AUX: read_byte = comparator_aux_control;
      `ADDR_FLAGS: read_byte = flags_view;
      default: read_byte = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= access;
      if (access && !i_wb_we) begin
        o_wb_dat <= {24'h000000, read_byte};
      end
    end
  end
endmodule
`default_nettype wire

// ---- comparator_control_wake_bench.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module comparator_control_wake_bench;
  logic clk = 0, rst = 1, cyc = 0, we = 0, slp = 0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd = 8'h0, r;
  logic [1:0] lvl = 2'h0, lat = 2'h2;
  wire [31:0] rd;
  wire ack, wake, nxt, br;
  wire [1:0] pam, on, rs, pin;
  wire [3:0] chs;
  wire [7:0] aux;
  int n_mismatch = 0, check_count = 0, cn = 0;
  cmp_analog_model m (.i_level(lvl), .o_plus_above_minus(pam));
  cmpctl_top uut (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat({24'h0, wd}), .o_wb_dat(rd), .o_wb_ack(ack), .i_plus_above_minus(pam),
    .i_port_latch(lat), .i_sleep_enter(slp), .o_comparator_on(on), .o_reference_select(rs),
    .o_channel_select(chs), .o_aux_control(aux), .o_result_pin(pin), .o_wake(wake),
    .o_run_next_first(nxt), .o_irq_branch(br));
  initial forever #2.5 clk = ~clk;
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rd[7:0];
    cyc <= 0;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task rc(input logic [3:0] a, input logic [7:0] e);
    wb(0, a, 8'h0);
    chk("register", e, r);
  endtask
  task t_reset;
    rc(4'h0, 8'h00);
    rc(4'h4, 8'h00);
    rc(4'h8, 8'h00);
    rc(4'h2, 8'h00);
    chk("aux output", 8'h00, aux);
    $display("reset values done");
  endtask
  task t_reset_again;
    wb(1, 4'h8, 8'h5a);
    wb(1, 4'h0, 8'hb7);
    chk("aux output", 8'h5a, aux);
    rst <= 1;
    wt(2);
    rst <= 0;
    rc(4'h0, 8'h00);
    rc(4'h4, 8'h00);
    rc(4'h8, 8'h00);
    chk("on bits", 8'h00, {6'h0, on});
    chk("aux output", 8'h00, aux);
    $display("reset again done");
  endtask
  task t_layout;
    lvl <= 2'h1;
    wb(1, 4'h0, 8'hff);
    wt(200);
    rc(4'h0, 8'hb7);
    chk("selects", 8'h53, {on, rs, chs});
    wb(1, 4'h0, 8'h80);
    wt(8);
    rc(4'h0, 8'hc0);
    $display("layout done");
  endtask
  task t_flag;
    wb(1, 4'hc, 8'h00);
    lvl <= 2'h0;
    wt(8);
    rc(4'hc, 8'h01);
    wb(1, 4'hc, 8'h00);
    wt(8);
    rc(4'hc, 8'h00);
    wb(1, 4'h0, 8'h80);
    lvl <= 2'h1;
    wt(8);
    rc(4'hc, 8'h01);
    $display("change flag done");
  endtask
  task t_sleep(input logic g);
    int k;
    wb(0, 4'h0, 8'h00);
    wb(1, 4'hc, {2'h0, g, 5'h14});
    slp <= 1;
    @(posedge clk);
    slp <= 0;
    lvl <= ~lvl;
    k = 0;
    while (wake !== 1'b1 && k < 30) begin
      @(posedge clk);
      k++;
    end
    chk("wake", 8'h03, {6'h0, wake, nxt});
    @(posedge clk);
    chk("branch", {7'h0, g}, {7'h0, br});
    wb(1, 4'hc, 8'h00);
    $display("sleep wake done");
  endtask
  task t_pin;
    wb(1, 4'h4, 8'h80);
    wb(1, 4'h0, 8'ha0);
    lvl <= 2'h1;
    wt(8);
    chk("pins", 8'h03, {6'h0, pin});
    wb(1, 4'h0, 8'h00);
    lat <= 2'h1;
    wt(2);
    chk("pins", 8'h01, {6'h0, pin});
    chk("on bits", 8'h02, {6'h0, on});
    $display("pins and off done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_reset;
    t_layout;
    t_flag;
    t_sleep(0);
    t_sleep(1);
    t_pin;
    t_reset_again;
    give_verdict;
  end
  always @(posedge clk) begin
    cn++;
    if (cn == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
endmodule
`default_nettype wire
